// ==== adc_mode_pkg.sv ====
// Purpose: shared constants and types for the converter mode control
// Assumes: 50 MHz system clock, serial pins synchronised inside the block
// Notes: times are kept in their own unit and converted to clock counts here
package adc_mode_pkg;

	// ****************************************
	// Frame edge counts
	// ****************************************
	localparam logic [4:0] FULL_POWER_EDGES = 5'h0a;
	localparam logic [4:0] GLITCH_EDGES = 5'h02;
	localparam logic [4:0] FRAME_EDGES = 5'h10;
	localparam logic [4:0] LEAD_ZEROS = 5'h04;
	localparam logic [4:0] TRACK_EDGES = 5'h0d;
	localparam int RESULT_BITS = 12;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int POWER_UP_NS = 1000;
	localparam int POWER_UP_CYC_INT =
		(POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] POWER_UP_CYCLES = 7'(POWER_UP_CYC_INT);

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_DOWN,
		MODE_WAKING
	} power_mode_t;

	typedef struct packed {
		logic frame_active;
		logic powered;
		logic tracking;
		logic data_valid;
	} status_t;

endpackage

// ==== adc_serial_power_mode_control.sv ====
// Purpose: digital mode and readout control of a serial SAR converter
// Assumes: serial clock and select are far slower than ref_clk_i
// Notes: reset state is normal mode; real power-on mode is undefined
`timescale 1ns/1ns
`default_nettype none

module adc_serial_power_mode_control (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Serial link pins
	input wire logic select_n_i,
	input wire logic serial_clk_i,
	output logic serial_result_out_o,
	output logic serial_result_oe_n_o,
	// Converter core
	input wire logic [11:0] result_i,
	output logic analog_power_o,
	output logic track_o,
	output adc_mode_pkg::status_t status_o
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] sel_sync_ff;
	logic [1:0] sck_sync_ff;
	logic sel_d_ff;
	logic sck_d_ff;

	// Two stages; only stage two feeds logic
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_sync_ff <= 2'h3;
			sck_sync_ff <= 2'h0;
			sel_d_ff <= 1'h1;
			sck_d_ff <= 1'h0;
		end else begin
			sel_sync_ff <= {sel_sync_ff[0], select_n_i};
			sck_sync_ff <= {sck_sync_ff[0], serial_clk_i};
			sel_d_ff <= sel_sync_ff[1];
			sck_d_ff <= sck_sync_ff[1];
		end
	end

	logic sel_fall;
	logic sel_rise;
	logic sck_fall;
	logic sck_edge;
	assign sel_fall = sel_d_ff & ~sel_sync_ff[1];
	assign sel_rise = ~sel_d_ff & sel_sync_ff[1];
	assign sck_fall = sck_d_ff & ~sck_sync_ff[1];
	assign sck_edge = sck_d_ff ^ sck_sync_ff[1];

	// ****************************************
	// Frame and mode state
	// ****************************************
	adc_mode_pkg::power_mode_t mode_ff, nxt_mode;
	logic [4:0] edge_cnt_ff, nxt_edge_cnt;
	logic [15:0] shift_ff, nxt_shift;
	logic active_ff, nxt_active;
	logic out_ff, nxt_out;
	logic oe_n_ff, nxt_oe_n;
	logic track_ff, nxt_track;
	logic power_ff, nxt_power;
	logic seen_edge_ff, nxt_seen_edge;
	logic [6:0] wake_cnt_ff, nxt_wake_cnt;
	logic warm_ff, nxt_warm;
	logic valid_ff, nxt_valid;

	// Count saturates so long frames never wrap into the power-down window
	function automatic logic [4:0] bump(input logic [4:0] c);
		bump = (c == 5'h1f) ? c : c + 5'h01;
	endfunction

	// Next-state logic for the whole frame
	always_comb begin
		nxt_mode = mode_ff;
		nxt_edge_cnt = edge_cnt_ff;
		nxt_shift = shift_ff;
		nxt_active = active_ff;
		nxt_out = out_ff;
		nxt_oe_n = oe_n_ff;
		nxt_track = track_ff;
		nxt_power = power_ff;
		nxt_seen_edge = seen_edge_ff;
		nxt_wake_cnt = wake_cnt_ff;
		nxt_warm = warm_ff;
		nxt_valid = valid_ff;
		// Power-up timer runs from wake start until done, even after the
		// frame has moved the mode on; idle while powered down
		if (power_ff && !warm_ff &&
			wake_cnt_ff != adc_mode_pkg::POWER_UP_CYCLES) begin
			nxt_wake_cnt = wake_cnt_ff + 7'h01;
		end
		if (power_ff &&
			wake_cnt_ff == adc_mode_pkg::POWER_UP_CYCLES) begin
			nxt_warm = 1'h1;
		end
		if (sel_fall) begin
			nxt_edge_cnt = 5'h00;
			nxt_active = 1'h1;
			nxt_track = 1'h0;
			nxt_oe_n = 1'h0;
			nxt_seen_edge = 1'h0;
			// Four zeros then result MSB first; first zero is out at once
			nxt_shift = {4'h0, result_i};
			nxt_out = 1'h0;
			nxt_valid = 1'h0;
			if (mode_ff == adc_mode_pkg::MODE_DOWN) begin
				nxt_mode = adc_mode_pkg::MODE_WAKING;
				nxt_power = 1'h1;
				nxt_wake_cnt = 7'h00;
				nxt_warm = 1'h0;
			end
		end else if (active_ff && sel_rise) begin
			nxt_active = 1'h0;
			nxt_oe_n = 1'h1;
			nxt_track = 1'h1;
			if (mode_ff == adc_mode_pkg::MODE_WAKING) begin
				if (edge_cnt_ff < adc_mode_pkg::FULL_POWER_EDGES) begin
					nxt_mode = adc_mode_pkg::MODE_DOWN;
					nxt_power = 1'h0;
					nxt_warm = 1'h0;
					nxt_track = 1'h0;
				end else begin
					nxt_mode = adc_mode_pkg::MODE_NORMAL;
				end
			end else if (edge_cnt_ff >= adc_mode_pkg::GLITCH_EDGES &&
				edge_cnt_ff < adc_mode_pkg::FULL_POWER_EDGES) begin
				nxt_mode = adc_mode_pkg::MODE_DOWN;
				nxt_power = 1'h0;
				nxt_warm = 1'h0;
				nxt_track = 1'h0;
			end // Below two edges: glitch, stay normal
		end else if (active_ff) begin
			// Wake frame: sampler tracks from its first serial edge
			if (sck_edge && !seen_edge_ff) begin
				nxt_seen_edge = 1'h1;
				if (mode_ff == adc_mode_pkg::MODE_WAKING) begin
					nxt_track = 1'h1;
				end
			end
			if (sck_fall) begin
				nxt_edge_cnt = bump(edge_cnt_ff);
				nxt_shift = {shift_ff[14:0], 1'h0};
				nxt_out = shift_ff[14];
				if (edge_cnt_ff == adc_mode_pkg::TRACK_EDGES - 5'h01) begin
					nxt_track = 1'h1; // back to track after conversion
				end
				if (edge_cnt_ff == adc_mode_pkg::FRAME_EDGES - 5'h01) begin
					nxt_oe_n = 1'h1;
					nxt_out = 1'h0;
					// Dummy result never marked valid
					nxt_valid = (mode_ff == adc_mode_pkg::MODE_NORMAL);
				end
			end
		end
		// Waking frame past ten edges and warm stays waking while active
		if (mode_ff == adc_mode_pkg::MODE_WAKING && active_ff && warm_ff &&
			edge_cnt_ff >= adc_mode_pkg::FULL_POWER_EDGES && !sel_rise) begin
			nxt_mode = mode_ff; // decided at release or frame end
		end
		if (mode_ff == adc_mode_pkg::MODE_WAKING && !active_ff && warm_ff) begin
			nxt_mode = adc_mode_pkg::MODE_NORMAL;
		end
	end

	// Registers for the frame state
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_ff <= adc_mode_pkg::MODE_NORMAL;
			edge_cnt_ff <= 5'h00;
			shift_ff <= 16'h0000;
			active_ff <= 1'h0;
			out_ff <= 1'h0;
			oe_n_ff <= 1'h1;
			track_ff <= 1'h1;
			power_ff <= 1'h1;
			seen_edge_ff <= 1'h0;
			wake_cnt_ff <= 7'h00;
			warm_ff <= 1'h1;
			valid_ff <= 1'h0;
		end else begin
			mode_ff <= nxt_mode;
			edge_cnt_ff <= nxt_edge_cnt;
			shift_ff <= nxt_shift;
			active_ff <= nxt_active;
			out_ff <= nxt_out;
			oe_n_ff <= nxt_oe_n;
			track_ff <= nxt_track;
			power_ff <= nxt_power;
			seen_edge_ff <= nxt_seen_edge;
			wake_cnt_ff <= nxt_wake_cnt;
			warm_ff <= nxt_warm;
			valid_ff <= nxt_valid;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign serial_result_out_o = out_ff;
	assign serial_result_oe_n_o = oe_n_ff;
	assign analog_power_o = power_ff;
	assign track_o = track_ff;
	assign status_o.frame_active = active_ff;
	assign status_o.powered = warm_ff;
	assign status_o.tracking = track_ff;
	assign status_o.data_valid = valid_ff;

endmodule // adc_serial_power_mode_control

`default_nettype wire

// ==== adc_host_model.sv ====
// Purpose: host side of the serial link, frames with a chosen edge count
// Assumes: pins change on falling ref_clk edges, 6 clocks per half period
// Notes: serial clock parks high outside frames
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
	// Clock
	input wire logic ref_clk_i,
	// Serial pins
	input wire logic data_i,
	output logic select_n_o,
	output logic serial_clk_o
);
	logic [15:0] word;
	int got;
	// ****************************************
	// Framing
	// ****************************************
	initial begin
		select_n_o = 1'b1; // Idles deselected
		serial_clk_o = 1'b1;
	end
	task automatic wait_n(input int c);
		repeat (c) @(negedge ref_clk_i);
	endtask
	// Shifts in bits on the high half, long after each fall settles
	task automatic frame(input int n);
		word = 16'h0000;
		select_n_o = 1'b0;
		wait_n(8);
		word = {word[14:0], data_i};
		got = 1;
		for (int k = 1; k <= n; k++) begin
			serial_clk_o = 1'b0; // Far under ten megahertz
			wait_n(6);
			serial_clk_o = 1'b1;
			wait_n(6);
			if (k < 16) begin
				word = {word[14:0], data_i};
				got++;
			end
		end
		select_n_o = 1'b1; // Edge count set by caller
		wait_n(12); // Quiet and acquisition time
	endtask
endmodule // adc_host_model
`default_nettype wire

// ==== adc_serial_power_mode_control_sva.sv ====
// Purpose: mode and framing checks at the block pins
// Assumes: pins slow against ref_clk_i
// Notes: edge count mirrors what the host sent
`timescale 1ns/1ns
`default_nettype none
module adc_mode_sva (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Pins
	input wire logic select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_result_out_o,
	input wire logic serial_result_oe_n_o,
	input wire logic analog_power_o,
	input wire logic track_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [4:0] cnt_ff;
	logic pwr_ff;
	// Edges in frame; power seen before detection lag
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_ff <= 5'h00;
			pwr_ff <= 1'b1;
		end else if ($fell(select_n_i)) begin
			cnt_ff <= 5'h00;
			pwr_ff <= analog_power_o;
		end else if (!select_n_i && $fell(serial_clk_i)) begin
			cnt_ff <= cnt_ff + 5'h01;
		end
	end
	sequence s_sel;
		$fell(select_n_i);
	endsequence
	sequence s_rel;
		$rose(select_n_i);
	endsequence
	property p_drive;
		s_sel |-> ##[2:5] (!serial_result_oe_n_o && !serial_result_out_o
			&& !track_o);
	endproperty
	property p_end;
		$fell(serial_clk_i) && !select_n_i && cnt_ff == 5'h0f
			|-> ##[2:6] serial_result_oe_n_o;
	endproperty
	property p_abort;
		s_rel |-> ##[2:6] serial_result_oe_n_o;
	endproperty
	property p_glitch;
		$rose(select_n_i) && pwr_ff && cnt_ff < 5'h02 |-> ##8 analog_power_o;
	endproperty
	property p_down;
		$rose(select_n_i) && pwr_ff && cnt_ff inside {[2:9]}
			|-> ##[2:6] !analog_power_o;
	endproperty
	property p_stay;
		$rose(select_n_i) && pwr_ff && cnt_ff > 5'h09 |-> ##8 analog_power_o;
	endproperty
	property p_back;
		$rose(select_n_i) && !pwr_ff && cnt_ff < 5'h0a
			|-> ##[2:6] !analog_power_o;
	endproperty
	property p_wake;
		$fell(select_n_i) && !analog_power_o |-> ##[2:5] analog_power_o;
	endproperty
	a_drive: assert property (p_drive) else $error("no drive");
	a_end: assert property (p_end) else $error("no float");
	a_abort: assert property (p_abort) else $error("no abort");
	a_glitch: assert property (p_glitch) else $error("glitch");
	a_down: assert property (p_down) else $error("no down");
	a_stay: assert property (p_stay) else $error("lost power");
	a_back: assert property (p_back) else $error("no back");
	a_wake: assert property (p_wake) else $error("no wake");
endmodule // adc_mode_sva
bind adc_serial_power_mode_control adc_mode_sva i_adc_mode_sva (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .select_n_i(select_n_i),
	.serial_clk_i(serial_clk_i), .serial_result_out_o(serial_result_out_o),
	.serial_result_oe_n_o(serial_result_oe_n_o),
	.analog_power_o(analog_power_o), .track_o(track_o));
`default_nettype wire

// ==== test_adc_serial_power_mode_control.sv ====
// Purpose: random and corner frames through the mode control
// Assumes: host model paces the pins
// Notes: read data checked only in frames that start powered
`timescale 1ns/1ns
`default_nettype none
module test_adc_serial_power_mode_control;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic select_n, serial_clk, out, oe_n, power, track;
	logic flip = 1'b0;
	logic [11:0] result = 12'h000;
	adc_mode_pkg::status_t status;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] lfsr = 32'h6af0;
	bit pwr = 1'b1;
	int corner [12] = '{1, 2, 9, 16, 5, 9, 10, 16, 0, 15, 3, 12};
	// ****************************************
	// Clock, design and host
	// ****************************************
	always #10 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) flip <= ~flip; // Released line never holds
	adc_serial_power_mode_control i_adc_serial_power_mode_control (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .select_n_i(select_n),
		.serial_clk_i(serial_clk), .serial_result_out_o(out),
		.serial_result_oe_n_o(oe_n), .result_i(result),
		.analog_power_o(power), .track_o(track), .status_o(status));
	adc_host_model i_adc_host_model (.ref_clk_i(ref_clk_i),
		.data_i(oe_n ? flip : out), .select_n_o(select_n),
		.serial_clk_o(serial_clk));
	function automatic logic [31:0] next_lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Powered: window 2..9 powers down; down: ten edges wake
	function automatic bit next_pwr(input bit p, input int k);
		return p ? (k < 2 || k > 9) : (k > 9);
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic run(input int k);
		bit p;
		p = pwr;
		lfsr = next_lfsr(lfsr);
		result = lfsr[11:0];
		i_adc_host_model.frame(k);
		pwr = next_pwr(p, k);
		check(16'(oe_n), 16'h0001);
		check(16'(power), 16'(pwr));
		check(16'({status, track}),
			16'({1'b0, pwr, pwr, p && k >= 16, pwr}));
		if (p) check(i_adc_host_model.word,
			{4'h0, result} >> (16 - i_adc_host_model.got));
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (6) @(negedge ref_clk_i);
		resetn_i = 1'b1;
		foreach (corner[j]) run(corner[j]);
		repeat (40) run(int'(lfsr[20:16]) % 17);
		end_of_test();
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			end_of_test();
		end
	end
endmodule // test_adc_serial_power_mode_control
`default_nettype wire
